// [flash_checker.sv]
// assertions on the ports of the serial flash front end
`timescale 1ns/1ps
module flash_checker import flash_pkg::*; #(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in,
  input wire logic hold_n,
  input wire logic wp_n,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic arr_req,
  input wire arr_cmd_type arr_cmd,
  input wire logic arr_ack,
  input wire logic [7:0] arr_rdata,
  input wire logic busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // completed array read and write
  sequence rd_done;
    arr_req && !arr_cmd.we && arr_ack;
  endsequence
  sequence wr_done;
    arr_req && arr_cmd.we && arr_ack;
  endsequence
  chk_oe_deselect: assert property (cs_n |-> !serial_out_oe && !serial_out)
    else $error("output driven while deselected");
  chk_oe_pause: assert property (!cs_n && !hold_n |-> !serial_out_oe)
    else $error("output driven while paused");
  chk_out_steady: assert property (sclk && $past(sclk) && !cs_n && !$past(cs_n)
    |-> $stable(serial_out))
    else $error("serial output moved while clock high");
  chk_req_stand: assert property (arr_req && !arr_ack |=> arr_req && $stable(arr_cmd))
    else $error("array request dropped or changed before ack");
  chk_busy_req: assert property (arr_req |-> busy)
    else $error("array active without busy");
  chk_prog_clear: assert property (rd_done |=> arr_req && arr_cmd.we
    && arr_cmd.addr == $past(arr_cmd.addr)
    && (arr_cmd.wdata & ~$past(arr_rdata)) == 8'h00)
    else $error("program write sets a bit");
  chk_erase_step: assert property (wr_done ##1 (arr_req && arr_cmd.we)
    |-> arr_cmd.addr == $past(arr_cmd.addr) + 21'h1 && arr_cmd.wdata == ERASED_BYTE)
    else $error("erase address step wrong");
  chk_erase_base: assert property (arr_req && arr_cmd.we && !$past(arr_req)
    |-> arr_cmd.addr[11:0] == 12'h000 && arr_cmd.wdata == ERASED_BYTE)
    else $error("erase starts off a sector base");
endmodule

// [flash_fifo.sv]
// small first-in first-out buffer with valid and ready on both sides
`timescale 1ns/1ps
module flash_fifo #(
  parameter int WIDTH = 29,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  // depth must be a power of two of at least two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  logic push;
  logic pop;

  // full when pointers differ only in the wrap bit
  assign in_ready = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_ptr_reg != rd_ptr_reg;
  assign out_data = mem[rd_ptr_reg[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  // pointers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else if (ce) begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule

// [flash_pkg.sv]
// constants, types and rule summary for the serial flash front end
// Summary of operation
// - serial input bits are sampled on the rising serial clock edge.
// - serial output advances to its next bit on the falling serial clock edge.
// - with select high the link side is idle and serial output is tri-stated.
// - deselecting never aborts a running erase, program or status write.
// - no instruction is taken until select has gone high then low after reset.
// - pause low while selected tri-states output and ignores clock and input.
// - write guard pin plus lock bit blocks status writes; range bits protect array.
// - one page program writes between one and 256 bytes.
// - programming only clears bits; only erase returns bits to one.
// - erase works per sector, per block or whole chip, never per page.
// - array holds 2,097,152 bytes, addresses 000000h to 1FFFFFh.
// - 512 sectors of 4 KB, sector n starts at n times 1000h.
// - 32 blocks of 64 KB, sixteen sectors each, block 0 at zero.
// - 8192 pages of 256 bytes on 256-byte boundaries.
// - clock idle low (mode 0) or idle high (mode 3), input on rising edges.
// - data-changing instructions need the write latch set first, else rejected.
package flash_pkg;
  localparam int ADDR_W = 21;
  localparam int ARRAY_BYTES = 2097152;
  localparam int BLOCK_LSB = 16;
  localparam int SECTOR_LSB = 12;
  localparam int PAGE_LSB = 8;
  localparam int BLOCK_COUNT = 32;
  localparam int SECTOR_COUNT = 512;
  localparam int PAGE_COUNT = 8192;
  localparam logic [8:0] PAGE_BYTES = 9'h100;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [9:0] FIRST_DATA_IDX = 10'h004;
  localparam logic [9:0] STATUS_BYTES = 10'h002;
  localparam int FIFO_DEPTH_DEF = 4;
  // instruction codes
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE = 8'hc7;
  // status byte fields and reset values
  localparam int ST_BUSY = 0;
  localparam int ST_LATCH = 1;
  localparam int ST_RANGE_LSB = 2;
  localparam int ST_LOCK = 7;
  localparam logic [2:0] RANGE_RESET = 3'h0;
  localparam logic LOCK_RESET = 1'b0;
  // first protected block for each range setting, 6'h20 means none
  localparam logic [7:0][5:0] PROT_FLOOR = {6'h00, 6'h00, 6'h10, 6'h18,
                                            6'h1c, 6'h1e, 6'h1f, 6'h20};
  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } arr_cmd_type;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] data;
  } prog_word_type;
  typedef enum logic [3:0] {
    ENG_IDLE = 4'h1,
    ENG_READ = 4'h2,
    ENG_WRITE = 4'h4,
    ENG_ERASE = 4'h8
  } eng_state_type;
endpackage

// [serial_flash_spi_front_end.sv]
// serial flash bus front end with protection and array engine
`timescale 1ns/1ps
module serial_flash_spi_front_end import flash_pkg::*; #(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic serial_in,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic serial_out,
  output logic serial_out_oe,
  output logic arr_req,
  output arr_cmd_type arr_cmd,
  input wire logic arr_ack,
  input wire logic [7:0] arr_rdata,
  output logic busy
);
  if (FIFO_DEPTH < 2) begin : g_bad_fifo
    $error("fifo depth below 2 cannot serve the program path");
  end

  // ---------------- link side, clocked by the serial clock
  logic [2:0] bit_cnt_reg;
  logic [6:0] in_shift_reg;
  logic op_done_reg;
  logic send_status_reg;
  logic [7:0] byte_hold_reg;
  logic byte_tgl_reg;
  logic [7:0] st_s1_reg;
  logic [7:0] st_s2_reg;
  logic [7:0] out_shift_reg;
  logic link_off;
  logic [7:0] status_word_reg;

  // bit counter and opcode watch, cleared whenever select is high
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      bit_cnt_reg <= 3'h0;
      in_shift_reg <= 7'h00;
      op_done_reg <= 1'b0;
      send_status_reg <= 1'b0;
    end else if (hold_n) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      in_shift_reg <= {in_shift_reg[5:0], serial_in};
      if (bit_cnt_reg == 3'h7 && !op_done_reg) begin
        op_done_reg <= 1'b1;
        send_status_reg <= {in_shift_reg, serial_in} == OP_READ_STATUS;
      end
    end
  end

  // each finished byte is held and announced by a toggle
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      byte_hold_reg <= 8'h00;
      byte_tgl_reg <= 1'b0;
    end else if (!cs_n && hold_n && bit_cnt_reg == 3'h7) begin
      byte_hold_reg <= {in_shift_reg, serial_in};
      byte_tgl_reg <= ~byte_tgl_reg;
    end
  end

  // status byte brought into the link domain, refreshed while clocks run
  always_ff @(posedge sclk or negedge reset_n) begin
    if (!reset_n) begin
      st_s1_reg <= 8'h00;
      st_s2_reg <= 8'h00;
    end else begin
      st_s1_reg <= status_word_reg;
      st_s2_reg <= st_s1_reg;
    end
  end

  // output shifter, advanced on falling edges
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      serial_out <= 1'b0;
      out_shift_reg <= 8'h00;
    end else if (hold_n && send_status_reg) begin
      if (bit_cnt_reg == 3'h0) begin
        serial_out <= st_s2_reg[7];
        out_shift_reg <= {st_s2_reg[6:0], 1'b0};
      end else begin
        serial_out <= out_shift_reg[7];
        out_shift_reg <= {out_shift_reg[6:0], 1'b0};
      end
    end
  end

  // output enable drops at once on deselect or pause
  assign link_off = cs_n | ~hold_n;
  always_ff @(negedge sclk or posedge link_off) begin
    if (link_off) begin
      serial_out_oe <= 1'b0;
    end else begin
      serial_out_oe <= send_status_reg;
    end
  end

  // ---------------- core side, clocked by clk
  logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
  logic tgl_s1_reg, tgl_s2_reg, tgl_s3_reg;
  logic wp_s1_reg, wp_s2_reg;

  // two-flop synchronisers, plus one edge stage for select and byte toggle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cs_s1_reg <= 1'b0;
      cs_s2_reg <= 1'b0;
      cs_s3_reg <= 1'b0;
      tgl_s1_reg <= 1'b0;
      tgl_s2_reg <= 1'b0;
      tgl_s3_reg <= 1'b0;
      wp_s1_reg <= 1'b0;
      wp_s2_reg <= 1'b0;
    end else if (ce) begin
      cs_s1_reg <= cs_n;
      cs_s2_reg <= cs_s1_reg;
      cs_s3_reg <= cs_s2_reg;
      tgl_s1_reg <= byte_tgl_reg;
      tgl_s2_reg <= tgl_s1_reg;
      tgl_s3_reg <= tgl_s2_reg;
      wp_s1_reg <= wp_n;
      wp_s2_reg <= wp_s1_reg;
    end
  end

  logic armed_reg, frame_ok_reg, end_pend_reg, byte_pend_reg;
  logic [7:0] byte_reg;
  logic [9:0] byte_idx_reg;
  logic [7:0] op_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [8:0] prog_cnt_reg;
  logic [7:0] new_status_reg;
  logic latch_reg, lock_reg;
  logic [2:0] range_reg;
  logic erase_go_reg;
  logic [ADDR_W-1:0] erase_base_reg, erase_last_reg;
  eng_state_type eng_reg;
  logic fifo_in_ready, fifo_out_valid, fifo_out_ready;
  prog_word_type fifo_out_word, work_reg;
  logic byte_evt, frame_start, frame_end, exec, push_want, take, busy_now;
  logic addr_locked, chip_locked, can_erase;

  assign byte_evt = tgl_s2_reg ^ tgl_s3_reg;
  assign frame_start = cs_s3_reg && !cs_s2_reg;
  assign frame_end = !cs_s3_reg && cs_s2_reg;
  assign exec = end_pend_reg && !byte_pend_reg;
  assign busy_now = eng_reg != ENG_IDLE || fifo_out_valid || erase_go_reg;

  // range protection by block index of the current address
  assign addr_locked = {1'b0, addr_reg[ADDR_W-1:BLOCK_LSB]} >= PROT_FLOOR[range_reg];
  assign chip_locked = range_reg != RANGE_RESET;
  assign can_erase = latch_reg && !busy_now;

  // program bytes that are allowed into the buffer
  assign push_want = frame_ok_reg && op_reg == OP_PAGE_PROGRAM
                     && byte_idx_reg >= FIRST_DATA_IDX && latch_reg && !addr_locked
                     && prog_cnt_reg < PAGE_BYTES;
  assign take = byte_pend_reg && (!push_want || fifo_in_ready);

  // arming after reset and frame bracketing
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      armed_reg <= 1'b0;
      frame_ok_reg <= 1'b0;
      end_pend_reg <= 1'b0;
    end else if (ce) begin
      if (cs_s2_reg) begin
        armed_reg <= 1'b1;
      end
      if (frame_start && armed_reg) begin
        frame_ok_reg <= 1'b1;
      end else if (exec) begin
        frame_ok_reg <= 1'b0;
      end
      if (frame_end && frame_ok_reg) begin
        end_pend_reg <= 1'b1;
      end else if (exec) begin
        end_pend_reg <= 1'b0;
      end
    end
  end

  // received byte waits here until the buffer can take it
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      byte_pend_reg <= 1'b0;
      byte_reg <= 8'h00;
    end else if (ce) begin
      if (byte_evt) begin
        byte_pend_reg <= frame_ok_reg;
        byte_reg <= byte_hold_reg;
      end else if (take) begin
        byte_pend_reg <= 1'b0;
      end
    end
  end

  // opcode, address and data byte bookkeeping
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      byte_idx_reg <= 10'h000;
      op_reg <= 8'h00;
      addr_reg <= '0;
      prog_cnt_reg <= 9'h000;
      new_status_reg <= 8'h00;
    end else if (ce) begin
      if (frame_start) begin
        byte_idx_reg <= 10'h000;
        prog_cnt_reg <= 9'h000;
      end else if (take) begin
        if (byte_idx_reg != 10'h3ff) begin
          byte_idx_reg <= byte_idx_reg + 10'h001;
        end
        if (byte_idx_reg == 10'h000) begin
          op_reg <= byte_reg;
        end else if (byte_idx_reg < FIRST_DATA_IDX) begin
          addr_reg <= {addr_reg[ADDR_W-9:0], byte_reg};
        end
        if (byte_idx_reg == 10'h001) begin
          new_status_reg <= byte_reg;
        end
        if (push_want) begin
          // stay inside the page, low byte wraps
          addr_reg[PAGE_LSB-1:0] <= addr_reg[PAGE_LSB-1:0] + 8'h01;
          prog_cnt_reg <= prog_cnt_reg + 9'h001;
        end
      end
    end
  end

  // write latch
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      latch_reg <= 1'b0;
    end else if (ce && exec && byte_idx_reg != 10'h000) begin
      case (op_reg)
        OP_WRITE_ENABLE: latch_reg <= latch_reg | !busy_now;
        OP_WRITE_DISABLE: latch_reg <= 1'b0;
        OP_WRITE_STATUS: if (can_erase && byte_idx_reg >= STATUS_BYTES) latch_reg <= 1'b0;
        OP_PAGE_PROGRAM: if (byte_idx_reg > FIRST_DATA_IDX) latch_reg <= 1'b0;
        OP_SECTOR_ERASE, OP_BLOCK_ERASE: begin
          if (can_erase && byte_idx_reg >= FIRST_DATA_IDX) latch_reg <= 1'b0;
        end
        OP_CHIP_ERASE: if (can_erase) latch_reg <= 1'b0;
        default: latch_reg <= latch_reg;
      endcase
    end
  end

  // range and lock bits, guarded by the write-guard pin
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      range_reg <= RANGE_RESET;
      lock_reg <= LOCK_RESET;
    end else if (ce && exec && op_reg == OP_WRITE_STATUS && can_erase
                 && byte_idx_reg >= STATUS_BYTES && !(lock_reg && !wp_s2_reg)) begin
      range_reg <= new_status_reg[ST_RANGE_LSB+2:ST_RANGE_LSB];
      lock_reg <= new_status_reg[ST_LOCK];
    end
  end

  // erase launch with sector, block or chip range
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      erase_go_reg <= 1'b0;
      erase_base_reg <= '0;
      erase_last_reg <= '0;
    end else if (ce) begin
      erase_go_reg <= 1'b0;
      if (exec && can_erase) begin
        case (op_reg)
          OP_SECTOR_ERASE: begin
            if (byte_idx_reg >= FIRST_DATA_IDX && !addr_locked) begin
              erase_go_reg <= 1'b1;
              erase_base_reg <= {addr_reg[ADDR_W-1:SECTOR_LSB], 12'h000};
              erase_last_reg <= {addr_reg[ADDR_W-1:SECTOR_LSB], 12'hfff};
            end
          end
          OP_BLOCK_ERASE: begin
            if (byte_idx_reg >= FIRST_DATA_IDX && !addr_locked) begin
              erase_go_reg <= 1'b1;
              erase_base_reg <= {addr_reg[ADDR_W-1:BLOCK_LSB], 16'h0000};
              erase_last_reg <= {addr_reg[ADDR_W-1:BLOCK_LSB], 16'hffff};
            end
          end
          OP_CHIP_ERASE: begin
            if (!chip_locked) begin
              erase_go_reg <= 1'b1;
              erase_base_reg <= '0;
              erase_last_reg <= '1;
            end
          end
          default: erase_go_reg <= 1'b0;
        endcase
      end
    end
  end

  flash_fifo #(
    .WIDTH($bits(prog_word_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_prog_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .in_valid(take && push_want),
    .in_ready(fifo_in_ready),
    .in_data({addr_reg, byte_reg}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_word)
  );
  assign fifo_out_ready = eng_reg == ENG_IDLE && !erase_go_reg;

  // array engine runs on regardless of select, so cycles finish
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      eng_reg <= ENG_IDLE;
    end else if (ce) begin
      case (eng_reg)
        ENG_IDLE: begin
          if (erase_go_reg) begin
            eng_reg <= ENG_ERASE;
          end else if (fifo_out_valid) begin
            eng_reg <= ENG_READ;
          end
        end
        ENG_READ: if (arr_ack) eng_reg <= ENG_WRITE;
        ENG_WRITE: if (arr_ack) eng_reg <= ENG_IDLE;
        ENG_ERASE: if (arr_ack && arr_cmd.addr == erase_last_reg) eng_reg <= ENG_IDLE;
        default: eng_reg <= ENG_IDLE;
      endcase
    end
  end

  // array request: read-modify-write for programs, fill with ones for erase
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      arr_req <= 1'b0;
      arr_cmd <= '0;
      work_reg <= '0;
    end else if (ce) begin
      case (eng_reg)
        ENG_IDLE: begin
          if (erase_go_reg) begin
            arr_req <= 1'b1;
            arr_cmd <= '{we: 1'b1, addr: erase_base_reg, wdata: ERASED_BYTE};
          end else if (fifo_out_valid) begin
            arr_req <= 1'b1;
            arr_cmd <= '{we: 1'b0, addr: fifo_out_word.addr, wdata: 8'h00};
            work_reg <= fifo_out_word;
          end
        end
        ENG_READ: begin
          if (arr_ack) begin
            arr_cmd.we <= 1'b1;
            arr_cmd.wdata <= arr_rdata & work_reg.data;
          end
        end
        ENG_WRITE: if (arr_ack) arr_req <= 1'b0;
        ENG_ERASE: begin
          if (arr_ack) begin
            if (arr_cmd.addr == erase_last_reg) begin
              arr_req <= 1'b0;
            end else begin
              arr_cmd.addr <= arr_cmd.addr + 21'h000001;
            end
          end
        end
        default: arr_req <= 1'b0;
      endcase
    end
  end

  // status byte and busy flag
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      status_word_reg <= 8'h00;
      busy <= 1'b0;
    end else if (ce) begin
      busy <= busy_now;
      status_word_reg <= '0;
      status_word_reg[ST_BUSY] <= busy_now;
      status_word_reg[ST_LATCH] <= latch_reg;
      status_word_reg[ST_RANGE_LSB+2:ST_RANGE_LSB] <= range_reg;
      status_word_reg[ST_LOCK] <= lock_reg;
    end
  end
endmodule

// [spi_host.sv]
// serial bus host driving select, clock, data and pause
`timescale 1ns/1ps
module spi_host (
  output logic sclk,
  output logic cs_n,
  output logic serial_in,
  output logic hold_n,
  input wire logic serial_out,
  input wire logic serial_out_oe
);
  logic [7:0] txq[$];
  logic [7:0] rxq[$];
  logic hold_oe;
  logic mode3;
  // idle levels land in the nonblocking region so the link flops see the select rise
  initial begin
    sclk <= 1'b0;
    cs_n <= 1'b1;
    serial_in <= 1'b1;
    hold_n <= 1'b1;
    hold_oe = 1'b0;
    mode3 = 1'b0;
  end
  // one frame msb first, clock idle low, or idle high with mode3; 8 paused clocks before byte h
  task automatic frame(input int h);
    logic [7:0] r;
    rxq = {};
    sclk = mode3;
    #6 cs_n = 1'b0;
    #10.5;
    for (int i = 0; i < txq.size(); i++) begin
      if (i == h) begin
        hold_n = 1'b0;
        repeat (8) begin
          serial_in = ~serial_in;
          #6 sclk = 1'b1;
          #6 sclk = 1'b0;
        end
        hold_oe = serial_out_oe;
        hold_n = 1'b1;
        #6;
      end
      for (int k = 7; k >= 0; k--) begin
        if (mode3) begin
          sclk = 1'b0;
        end
        serial_in = txq[i][k];
        #6 sclk = 1'b1;
        r[k] = serial_out_oe ? serial_out : 1'b1; // released line reads as pulled up
        #6;
        if (!mode3) begin
          sclk = 1'b0;
        end
      end
      rxq.push_back(r);
    end
    #20 cs_n = 1'b1;
    serial_in = ~serial_in; // released line must not keep its value
    #60;
  endtask
endmodule

// [tb_top.sv]
// testbench for the serial flash front end
`timescale 1ns/1ps
module tb_top import flash_pkg::*; ;
  logic clk = 1'b0;
  logic reset_n;
  logic ce = 1'b1;
  logic wp_n = 1'b1;
  logic arr_ack = 1'b0;
  logic [7:0] arr_rdata = 8'h00;
  logic sclk, cs_n, serial_in, hold_n, serial_out, serial_out_oe, arr_req, busy;
  arr_cmd_type arr_cmd;
  logic [7:0] mem [int];
  logic [20:0] wlo, whi;
  int n_errors = 0;
  int samples_checked = 0;
  int nacc = 0;
  int nwr = 0;
  int lat = 0;
  int w = 0;
  // core clock
  always #2 clk = ~clk;
  serial_flash_spi_front_end u_serial_flash_spi_front_end (.clk(clk), .reset_n(reset_n),
    .ce(ce), .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in), .hold_n(hold_n), .wp_n(wp_n),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe), .arr_req(arr_req),
    .arr_cmd(arr_cmd), .arr_ack(arr_ack), .arr_rdata(arr_rdata), .busy(busy));
  spi_host u_spi_host (.sclk(sclk), .cs_n(cs_n), .serial_in(serial_in), .hold_n(hold_n),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe));
  // byte array, ack lat+1 cycles after the request is seen
  always @(posedge clk) begin
    arr_ack <= 1'b0;
    if (arr_req && !arr_ack) begin
      if (w >= lat) begin
        arr_ack <= 1'b1;
        w <= 0;
        nacc <= nacc + 1;
        if (arr_cmd.we) begin
          mem[arr_cmd.addr] = arr_cmd.wdata;
          if (nwr == 0) wlo <= arr_cmd.addr;
          whi <= arr_cmd.addr;
          nwr <= nwr + 1;
        end else begin
          arr_rdata <= mem.exists(arr_cmd.addr) ? mem[arr_cmd.addr] : ERASED_BYTE;
        end
      end else begin
        w <= w + 1;
      end
    end
  end
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // frame, then bounded wait for busy to clear
  task automatic go(input int h);
    int i;
    u_spi_host.frame(h);
    i = 0;
    while (busy !== 1'b0 && i < 20000) begin
      @(posedge clk);
      i++;
    end
    if (busy !== 1'b0) begin
      n_errors++;
      $display("BAD %0t busy stuck", $time);
      stop_test();
    end
  endtask
  task automatic wr_en();
    u_spi_host.txq = {OP_WRITE_ENABLE};
    go(-1);
  endtask
  // status read of two repeated bytes, masked
  task automatic rd(input logic [7:0] m, input logic [7:0] exp, input int h);
    u_spi_host.txq = {OP_READ_STATUS, 8'h00, 8'h00};
    go(h);
    check({u_spi_host.rxq[1] & m, u_spi_host.rxq[2] & m}, {exp, exp});
  endtask
  task automatic t_latch();
    rd(8'hff, 8'h00, -1);
    wr_en();
    rd(8'hff, 8'h02, 0);
    check(u_spi_host.hold_oe, 1'b0);
    u_spi_host.txq = {OP_WRITE_DISABLE};
    go(-1);
    rd(8'hff, 8'h00, -1);
  endtask
  task automatic t_refused();
    logic [7:0] ops [4];
    ops = '{OP_PAGE_PROGRAM, OP_SECTOR_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE};
    nacc = 0;
    foreach (ops[i]) begin
      u_spi_host.txq = {ops[i], 8'h00, 8'h20, 8'h00, 8'h55};
      go(-1);
    end
    check(nacc, 0);
  endtask
  // slow array so program bytes queue up; top address bits dropped
  task automatic t_program();
    logic [7:0] d;
    lat = 20;
    nacc = 0;
    mem[21'h1ff0f1] = 8'h0f;
    wr_en();
    u_spi_host.txq = {OP_PAGE_PROGRAM, 8'hff, 8'hf0, 8'hf0};
    for (int i = 0; i < 5; i++) u_spi_host.txq.push_back(8'ha5 ^ i[7:0]);
    go(-1);
    for (int i = 0; i < 5; i++) begin
      d = 8'ha5 ^ i[7:0];
      check(mem[21'h1ff0f0 + i], (i == 1) ? (d & 8'h0f) : d);
    end
    check(nacc, 10);
    rd(8'hff, 8'h00, -1);
  endtask
  task automatic t_erase();
    lat = 0;
    nwr = 0;
    wr_en();
    u_spi_host.txq = {OP_SECTOR_ERASE, 8'h1f, 8'hf1, 8'h23};
    go(-1);
    check(nwr, 4096);
    check({wlo, whi}, {21'h1ff000, 21'h1fffff});
    check(mem[21'h1ff0f1], ERASED_BYTE);
  endtask
  task automatic t_protect();
    wr_en();
    u_spi_host.txq = {OP_WRITE_STATUS, 8'h84, 8'h00};
    go(-1);
    rd(8'hff, 8'h84, -1);
    @(posedge clk);
    wp_n <= 1'b0;
    wr_en();
    u_spi_host.txq = {OP_WRITE_STATUS, 8'h00, 8'h00};
    go(-1);
    rd(8'hfd, 8'h84, -1);
    wr_en();
    nacc = 0;
    u_spi_host.txq = {OP_PAGE_PROGRAM, 8'h1f, 8'h00, 8'h00, 8'h00};
    go(-1);
    check(nacc, 0);
    @(posedge clk);
    wp_n <= 1'b1;
    wr_en();
    u_spi_host.txq = {OP_WRITE_STATUS, 8'h00, 8'h00};
    go(-1);
    rd(8'hff, 8'h00, -1);
  endtask
  // core frozen by the clock enable: a write enable sent meanwhile is lost
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    wr_en();
    @(posedge clk);
    ce <= 1'b1;
    rd(8'hff, 8'h00, -1);
  endtask
  // latch set and cleared again with the serial clock idling high
  task automatic t_mode3();
    u_spi_host.mode3 = 1'b1;
    wr_en();
    rd(8'hff, 8'h02, -1);
    u_spi_host.txq = {OP_WRITE_DISABLE};
    go(-1);
    rd(8'hff, 8'h00, -1);
    u_spi_host.mode3 = 1'b0;
  endtask
  // main sequence; the unknown-to-low step of reset also clears the link-side byte hold, toggle and status flops
  initial begin
    reset_n <= 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_latch();
    t_freeze();
    t_mode3();
    t_refused();
    t_program();
    t_erase();
    t_protect();
    stop_test();
  end
endmodule
bind serial_flash_spi_front_end flash_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_flash_checker (
  .clk(clk), .reset_n(reset_n), .ce(ce), .sclk(sclk), .cs_n(cs_n), .serial_in(serial_in),
  .hold_n(hold_n), .wp_n(wp_n), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
  .arr_req(arr_req), .arr_cmd(arr_cmd), .arr_ack(arr_ack), .arr_rdata(arr_rdata),
  .busy(busy));
